// ==== hdl/ssl_superspeed_map.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 200 MHz system clock
// Notes: Definitions only
`ifndef SSL_SUPERSPEED_MAP_SVH
`define SSL_SUPERSPEED_MAP_SVH

// Register offsets and reset values
`define SSL_REG_GAIN 8'h21
`define SSL_REG_LINK 8'h22
`define SSL_GAIN_RST 4'h0
`define SSL_LINK_CTRL_RST 7'h04
`define SSL_LINK_STAT_BIT 7
`define SSL_GAIN_MSB 3
`define SSL_RD_UNMAPPED 8'h00

// Compliance force encodings
`define SSL_CMP_FSM 2'h0
`define SSL_CMP_DFP 2'h1
`define SSL_CMP_UFP 2'h2
`define SSL_CMP_OFF 2'h3

// Target address with both address straps floating
`define SSL_I2C_ADDR_BASE 7'h12
`define SSL_STRAP_FLOAT 2'h0

// I2C bit positions within a byte slot
`define SSL_BIT_LAST 4'h7
`define SSL_BIT_ACK 4'h8

// Timing
`define SSL_CLK_MHZ 200
`define SSL_DEBOUNCE_US 200
`define SSL_DEBOUNCE_CYC (`SSL_DEBOUNCE_US * `SSL_CLK_MHZ)
`define SSL_DET_P0_MS 8
`define SSL_DET_P1_MS 12
`define SSL_DET_P2_MS 48
`define SSL_DET_P3_MS 96
`define SSL_DET_P0_CYC (`SSL_DET_P0_MS * 1000 * `SSL_CLK_MHZ)
`define SSL_DET_P1_CYC (`SSL_DET_P1_MS * 1000 * `SSL_CLK_MHZ)
`define SSL_DET_P2_CYC (`SSL_DET_P2_MS * 1000 * `SSL_CLK_MHZ)
`define SSL_DET_P3_CYC (`SSL_DET_P3_MS * 1000 * `SSL_CLK_MHZ)

`endif

// ==== hdl/ssl_superspeed_pkg.sv ====
// Purpose: Types shared by the link control register bank
// Assumes: Nothing beyond the map header
// Notes: Field order of the link struct matches register bits 6:0
package ssl_superspeed_pkg;

  typedef enum logic [2:0] {
    SSL_ST_ADDR,
    SSL_ST_REG,
    SSL_ST_WR,
    SSL_ST_RD,
    SSL_ST_IDLE
  } ssl_state_e;

  typedef struct packed {
    logic lfps_gain;
    logic exit_debounce;
    logic detect_inhibit;
    logic [1:0] detect_period;
    logic [1:0] compliance_force;
  } ssl_link_ctrl_s;

  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] data;
  } ssl_wr_evt_s;

endpackage

// ==== hdl/ssl_sync2.sv ====
// Purpose: Two-flop synchroniser for a bundle of independent levels
// Assumes: Each bit is a level; bits are not coherent with each other
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module ssl_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

// ==== hdl/ssl_superspeed_regs.sv ====
// Purpose: Link control registers behind an I2C target clocked by scl
// Assumes: scl stops between frames; register values cross as quasi-static words
// Notes: Straps are captured shortly after reset release
// How it works
// - Upstream receiver gain select in 0x21 bits 3:0 picks gain from zero to 9 dB.
// - With override clear, the gain field reads back the sampled gain strap pins.
// - With override set, a host write to the gain field sets receiver gain.
// - The register gain control offers sixteen settings in a four-bit field; the two gain strap pins give only four.
// - In I2C mode gain is set from registers only with override set; otherwise the gain straps set it.
// - Bit 7 of 0x22 reads one while in compliance mode, else zero.
// - Bit 6 of 0x22 clear forces zero gain during LFPS; set keeps selections.
// - Bit 5 of 0x22 set debounces LFPS 200 us before low-power exit.
// - Bit 4 of 0x22 set suppresses receiver detection in U2 and U3.
// - Bits 3:2 of 0x22 pick detect interval 8, 12, 48 or 96 ms.
// - Bits 1:0 of 0x22: FSM, force downstream, force upstream, or disabled compliance.
// - Target address is 0x12 with both address straps floating.
`timescale 1ns/1ps
`include "ssl_superspeed_map.svh"
module ssl_superspeed_regs #(
  parameter int DEBOUNCE_CYC = `SSL_DEBOUNCE_CYC,
  parameter int DET_P0_CYC = `SSL_DET_P0_CYC,
  parameter int DET_P1_CYC = `SSL_DET_P1_CYC,
  parameter int DET_P2_CYC = `SSL_DET_P2_CYC,
  parameter int DET_P3_CYC = `SSL_DET_P3_CYC
) (
  // System
  input wire logic clk,
  input wire logic reset_n,
  // I2C link
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Mode and straps
  input wire logic i2c_mode_select,
  input wire logic [1:0] address_strap_high,
  input wire logic [1:0] address_strap_low,
  input wire logic [1:0] upstream_gain_strap_pins,
  input wire logic gain_software_override,
  // Receiver status
  input wire logic lfps_detect,
  input wire logic low_power_state,
  input wire logic [1:0] compliance_fsm_req,
  // Receiver controls
  output logic [3:0] upstream_rx_gain_select,
  output logic low_power_exit,
  output logic rx_detect_enable,
  output logic rx_detect_strobe,
  output logic compliance_dfp,
  output logic compliance_ufp,
  output logic compliance_state_flag
);
  localparam int DCW = $clog2(DEBOUNCE_CYC + 1);
  localparam int PCW = $clog2(DET_P3_CYC + 1);

  // Synchronised pins
  logic [14:0] sync_in;
  logic [14:0] sync_q;
  logic wr_tgl_s, lp_s, lfps_s, ovr_s, mode_s, sda_s, scl_s;
  logic [1:0] cmp_req_s, gstrap_s, a1_s, a0_s;
  // System domain state
  logic scl_d_ff, sda_d_ff, hold_ff, armed_ff, strap_done_ff, wr_tgl_d_ff;
  logic [1:0] strap_age_ff;
  logic [3:0] gain_strap_ff, gain_wr_ff, gain_out_ff, snap_gain_ff;
  logic [6:0] dev_addr_ff;
  logic [7:0] snap_link_ff;
  logic [DCW-1:0] deb_cnt_ff;
  logic [PCW-1:0] det_cnt_ff;
  logic [PCW-1:0] period_lim;
  logic exit_ff, rx_en_ff, strobe_ff, dfp_ff, ufp_ff, cmp_flag_ff;
  logic nxt_dfp, nxt_ufp;
  logic [3:0] gain_eff;
  logic start_det, stop_det, wr_evt;
  ssl_superspeed_pkg::ssl_link_ctrl_s link_ctrl_ff;
  // Link domain state
  logic eng_rst_n;
  ssl_superspeed_pkg::ssl_state_e state_ff;
  logic [3:0] cnt_ff;
  logic [3:0] bit_idx;
  logic [6:0] shift_ff;
  logic [7:0] byte_in, ptr_ff, rd_byte;
  logic ack_ff, rd_req_ff, wr_tgl_ff, sda_oe_ff;
  ssl_superspeed_pkg::ssl_wr_evt_s wr_ev_ff;

  assign sync_in = {wr_tgl_ff, compliance_fsm_req, low_power_state, lfps_detect, gain_software_override,
                    upstream_gain_strap_pins, address_strap_high, address_strap_low, i2c_mode_select,
                    sda_in, scl};

  ssl_sync2 #(
    .WIDTH(15)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(sync_in),
    .q(sync_q)
  );

  assign {wr_tgl_s, cmp_req_s, lp_s, lfps_s, ovr_s, gstrap_s, a1_s, a0_s, mode_s, sda_s, scl_s} = sync_q;

  // Straps settle through the synchroniser before capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_age_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      gain_strap_ff <= `SSL_GAIN_RST;
      dev_addr_ff <= `SSL_I2C_ADDR_BASE;
    end else if (!strap_done_ff) begin
      strap_age_ff <= strap_age_ff + 2'h1;
      if (strap_age_ff == 2'h2) begin
        strap_done_ff <= 1'b1;
        gain_strap_ff <= {2'h0, gstrap_s};
        dev_addr_ff <= `SSL_I2C_ADDR_BASE + {3'h0, a1_s, a0_s};
      end
    end
  end

  // Start and stop seen by oversampling the bus
  assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;

  // Link engine is held in reset outside frames; release only while scl is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      hold_ff <= 1'b1;
      armed_ff <= 1'b0;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      if (!mode_s || !strap_done_ff) begin
        hold_ff <= 1'b1;
        armed_ff <= 1'b0;
      end else if (start_det) begin
        hold_ff <= 1'b1;
        armed_ff <= 1'b1;
      end else if (stop_det) begin
        hold_ff <= 1'b1;
        armed_ff <= 1'b0;
      end else if (armed_ff && !scl_s) begin
        hold_ff <= 1'b0;
        armed_ff <= 1'b0;
      end
    end
  end

  // Readback words refresh only while the engine is held, so they never move under scl
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_gain_ff <= `SSL_GAIN_RST;
      snap_link_ff <= {1'b0, `SSL_LINK_CTRL_RST};
    end else if (hold_ff) begin
      snap_gain_ff <= gain_eff;
      snap_link_ff <= {cmp_flag_ff, link_ctrl_ff};
    end
  end

  // Write events arrive as a toggle; offset and data are stable by then
  assign wr_evt = wr_tgl_s ^ wr_tgl_d_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_tgl_d_ff <= 1'b0;
      gain_wr_ff <= `SSL_GAIN_RST;
      link_ctrl_ff <= `SSL_LINK_CTRL_RST;
    end else begin
      wr_tgl_d_ff <= wr_tgl_s;
      if (wr_evt && wr_ev_ff.offset == `SSL_REG_GAIN) begin
        gain_wr_ff <= wr_ev_ff.data[`SSL_GAIN_MSB:0];
      end
      if (wr_evt && wr_ev_ff.offset == `SSL_REG_LINK) begin
        link_ctrl_ff <= wr_ev_ff.data[`SSL_LINK_STAT_BIT-1:0];
      end
    end
  end

  // Register gain applies only in I2C mode with override set
  assign gain_eff = (mode_s && ovr_s) ? gain_wr_ff : gain_strap_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gain_out_ff <= `SSL_GAIN_RST;
    end else if (lfps_s && !link_ctrl_ff.lfps_gain) begin
      gain_out_ff <= 4'h0;
    end else begin
      gain_out_ff <= gain_eff;
    end
  end

  // Low-power exit, optionally debounced
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      deb_cnt_ff <= '0;
      exit_ff <= 1'b0;
    end else begin
      if (lfps_s && lp_s) begin
        if (deb_cnt_ff != DCW'(DEBOUNCE_CYC)) begin
          deb_cnt_ff <= deb_cnt_ff + DCW'(1);
        end
      end else begin
        deb_cnt_ff <= '0;
      end
      exit_ff <= lp_s && lfps_s && (!link_ctrl_ff.exit_debounce || deb_cnt_ff >= DCW'(DEBOUNCE_CYC - 1));
    end
  end

  // Receiver detect interval
  always_comb begin
    unique case (link_ctrl_ff.detect_period)
      2'h0: period_lim = PCW'(DET_P0_CYC - 1);
      2'h1: period_lim = PCW'(DET_P1_CYC - 1);
      2'h2: period_lim = PCW'(DET_P2_CYC - 1);
      2'h3: period_lim = PCW'(DET_P3_CYC - 1);
    endcase
  end

  // Shortening the interval takes effect at once since the compare is greater-or-equal
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      det_cnt_ff <= '0;
      strobe_ff <= 1'b0;
      rx_en_ff <= 1'b1;
    end else begin
      rx_en_ff <= !(link_ctrl_ff.detect_inhibit && lp_s);
      if (det_cnt_ff >= period_lim) begin
        det_cnt_ff <= '0;
        strobe_ff <= rx_en_ff;
      end else begin
        det_cnt_ff <= det_cnt_ff + PCW'(1);
        strobe_ff <= 1'b0;
      end
    end
  end

  // Compliance control
  always_comb begin
    unique case (link_ctrl_ff.compliance_force)
      `SSL_CMP_FSM: {nxt_ufp, nxt_dfp} = cmp_req_s;
      `SSL_CMP_DFP: {nxt_ufp, nxt_dfp} = 2'h1;
      `SSL_CMP_UFP: {nxt_ufp, nxt_dfp} = 2'h2;
      `SSL_CMP_OFF: {nxt_ufp, nxt_dfp} = 2'h0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dfp_ff <= 1'b0;
      ufp_ff <= 1'b0;
      cmp_flag_ff <= 1'b0;
    end else begin
      dfp_ff <= nxt_dfp;
      ufp_ff <= nxt_ufp;
      cmp_flag_ff <= nxt_dfp || nxt_ufp;
    end
  end

  // Link side: bits sampled on rising scl, sda driven on falling scl
  assign eng_rst_n = reset_n & ~hold_ff;
  assign byte_in = {shift_ff, sda_in};

  always_ff @(posedge scl or negedge eng_rst_n) begin
    if (!eng_rst_n) begin
      state_ff <= ssl_superspeed_pkg::SSL_ST_ADDR;
      cnt_ff <= 4'h0;
      shift_ff <= 7'h00;
      ack_ff <= 1'b0;
      rd_req_ff <= 1'b0;
    end else begin
      shift_ff <= byte_in[6:0];
      cnt_ff <= (cnt_ff == `SSL_BIT_ACK) ? 4'h0 : cnt_ff + 4'h1;
      if (cnt_ff == `SSL_BIT_LAST) begin
        rd_req_ff <= byte_in[0];
        if (state_ff == ssl_superspeed_pkg::SSL_ST_ADDR) begin
          ack_ff <= (byte_in[7:1] == dev_addr_ff);
        end else begin
          ack_ff <= (state_ff == ssl_superspeed_pkg::SSL_ST_REG) || (state_ff == ssl_superspeed_pkg::SSL_ST_WR);
        end
      end
      if (cnt_ff == `SSL_BIT_ACK) begin
        ack_ff <= 1'b0;
        unique case (state_ff)
          ssl_superspeed_pkg::SSL_ST_ADDR: begin
            if (!ack_ff) begin
              state_ff <= ssl_superspeed_pkg::SSL_ST_IDLE;
            end else if (rd_req_ff) begin
              state_ff <= ssl_superspeed_pkg::SSL_ST_RD;
            end else begin
              state_ff <= ssl_superspeed_pkg::SSL_ST_REG;
            end
          end
          ssl_superspeed_pkg::SSL_ST_REG: state_ff <= ssl_superspeed_pkg::SSL_ST_WR;
          ssl_superspeed_pkg::SSL_ST_WR: state_ff <= ssl_superspeed_pkg::SSL_ST_WR;
          ssl_superspeed_pkg::SSL_ST_RD: begin
            state_ff <= sda_in ? ssl_superspeed_pkg::SSL_ST_IDLE : ssl_superspeed_pkg::SSL_ST_RD;
          end
          ssl_superspeed_pkg::SSL_ST_IDLE: state_ff <= ssl_superspeed_pkg::SSL_ST_IDLE;
        endcase
      end
    end
  end

  // Offset pointer survives a repeated start so write-offset-then-read works
  always_ff @(posedge scl or negedge reset_n) begin
    if (!reset_n) begin
      ptr_ff <= 8'h00;
      wr_tgl_ff <= 1'b0;
      wr_ev_ff <= '0;
    end else if (cnt_ff == `SSL_BIT_LAST && state_ff == ssl_superspeed_pkg::SSL_ST_REG) begin
      ptr_ff <= byte_in;
    end else if (cnt_ff == `SSL_BIT_LAST && state_ff == ssl_superspeed_pkg::SSL_ST_WR) begin
      wr_ev_ff <= {ptr_ff, byte_in};
      wr_tgl_ff <= ~wr_tgl_ff;
      ptr_ff <= ptr_ff + 8'h01;
    end else if (cnt_ff == `SSL_BIT_ACK && state_ff == ssl_superspeed_pkg::SSL_ST_RD) begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

  always_comb begin
    if (ptr_ff == `SSL_REG_GAIN) begin
      rd_byte = {4'h0, snap_gain_ff};
    end else if (ptr_ff == `SSL_REG_LINK) begin
      rd_byte = snap_link_ff;
    end else begin
      rd_byte = `SSL_RD_UNMAPPED;
    end
  end

  assign bit_idx = `SSL_BIT_LAST - cnt_ff;

  always_ff @(negedge scl or negedge eng_rst_n) begin
    if (!eng_rst_n) begin
      sda_oe_ff <= 1'b0;
    end else if (cnt_ff == `SSL_BIT_ACK) begin
      sda_oe_ff <= ack_ff;
    end else if (state_ff == ssl_superspeed_pkg::SSL_ST_RD) begin
      sda_oe_ff <= ~rd_byte[bit_idx[2:0]];
    end else begin
      sda_oe_ff <= 1'b0;
    end
  end

  // Open drain: only the enable moves
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_ff;
  assign upstream_rx_gain_select = gain_out_ff;
  assign low_power_exit = exit_ff;
  assign rx_detect_enable = rx_en_ff;
  assign rx_detect_strobe = strobe_ff;
  assign compliance_dfp = dfp_ff;
  assign compliance_ufp = ufp_ff;
  assign compliance_state_flag = cmp_flag_ff;

  // Checks
  chk_gain_strap_read: assert property (@(posedge clk) disable iff (!reset_n)
    hold_ff && !ovr_s && strap_done_ff |=> snap_gain_ff == $past(gain_strap_ff))
    else $error("gain readback not strap value");
  chk_gain_write_apply: assert property (@(posedge clk) disable iff (!reset_n)
    wr_evt && wr_ev_ff.offset == `SSL_REG_GAIN && mode_s && ovr_s && !lfps_s
    |=> ##1 gain_out_ff == $past(wr_ev_ff.data[3:0], 2))
    else $error("written gain not applied");
  chk_lfps_zero_gain: assert property (@(posedge clk) disable iff (!reset_n)
    lfps_s && !link_ctrl_ff.lfps_gain |=> gain_out_ff == 4'h0)
    else $error("gain not zero during lfps");
  chk_lfps_keep_gain: assert property (@(posedge clk) disable iff (!reset_n)
    lfps_s && link_ctrl_ff.lfps_gain |=> gain_out_ff == $past(gain_eff))
    else $error("gain lost during lfps");
  chk_exit_no_debounce: assert property (@(posedge clk) disable iff (!reset_n)
    !link_ctrl_ff.exit_debounce && lfps_s && lp_s |=> exit_ff)
    else $error("exit late without debounce");
  chk_exit_debounced: assert property (@(posedge clk) disable iff (!reset_n)
    link_ctrl_ff.exit_debounce && $rose(lfps_s) ##1 link_ctrl_ff.exit_debounce |-> !exit_ff [*2])
    else $error("exit before debounce");
  chk_detect_inhibit: assert property (@(posedge clk) disable iff (!reset_n)
    link_ctrl_ff.detect_inhibit && lp_s |=> !rx_en_ff ##1 !strobe_ff)
    else $error("detect not inhibited");
  chk_compliance_flag: assert property (@(posedge clk) disable iff (!reset_n)
    link_ctrl_ff.compliance_force == `SSL_CMP_OFF |=> !cmp_flag_ff && !dfp_ff && !ufp_ff)
    else $error("compliance flag set while disabled");
  chk_compliance_force: assert property (@(posedge clk) disable iff (!reset_n)
    (link_ctrl_ff.compliance_force == `SSL_CMP_DFP) [*2] |-> dfp_ff && !ufp_ff)
    else $error("downstream force ignored");
  chk_addr_ack_match: assert property (@(posedge scl) disable iff (!eng_rst_n)
    state_ff == ssl_superspeed_pkg::SSL_ST_ADDR && cnt_ff == `SSL_BIT_LAST && byte_in[7:1] == dev_addr_ff
    |=> ack_ff ##1 state_ff != ssl_superspeed_pkg::SSL_ST_IDLE)
    else $error("address match not acked");

  cov_reg_write: cover property (@(posedge clk) disable iff (!reset_n) wr_evt);
  cov_debounced_exit: cover property (@(posedge clk) disable iff (!reset_n) link_ctrl_ff.exit_debounce && $rose(exit_ff));
  cov_detect_strobe: cover property (@(posedge clk) disable iff (!reset_n) strobe_ff);
  cov_read_byte: cover property (@(posedge scl) disable iff (!eng_rst_n) state_ff == ssl_superspeed_pkg::SSL_ST_RD);
endmodule

// ==== tb/ssl_i2c_host.sv ====
// Purpose: I2C controller model that reaches the link control registers
// Assumes: sda is open drain, resolved with a pull-up in the bench
// Notes: scl stands high between frames; 64 ns bit period
`timescale 1ns/1ps
module ssl_i2c_host (
  // Wire
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  logic in_frame;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    in_frame = 1'b0;
  end

  // Data moves only while scl is low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #8 sda_low = ~b;
    #24 scl = 1'b1;
    #1 r = sda;
    #31;
  endtask

  task automatic start_cond();
    if (in_frame) begin
      scl = 1'b0;
      #8 sda_low = 1'b0;
      #24 scl = 1'b1;
    end
    #600 sda_low = 1'b1;
    #600 in_frame = 1'b1;
  endtask

  task automatic stop_cond();
    scl = 1'b0;
    #8 sda_low = 1'b1;
    #24 scl = 1'b1;
    #600 sda_low = 1'b0;
    #600 in_frame = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] b, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ok = ok & ~r;
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d, output logic ok);
    // Off the clk grid so synchroniser inputs never move on a clk edge
    #0.3;
    ok = 1'b1;
    start_cond();
    put_byte({a, 1'b0}, ok);
    put_byte(off, ok);
    put_byte(d, ok);
    stop_cond();
  endtask

  task automatic read_reg(input logic [6:0] a, input logic [7:0] off, output logic [7:0] d, output logic ok);
    logic r;
    #0.3;
    ok = 1'b1;
    start_cond();
    put_byte({a, 1'b0}, ok);
    put_byte(off, ok);
    start_cond();
    put_byte({a, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    stop_cond();
  endtask
endmodule

// ==== tb/superspeed_eq_link_ctrl_regs_test.sv ====
// Purpose: Self-checking bench for the link control register bank
// Assumes: Shortened debounce and detect counts set below
// Notes: Inputs change 1 ns after a rising clk edge
`timescale 1ns/1ps
module superspeed_eq_link_ctrl_regs_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic scl, sda, sda_low, sda_out, sda_oe;
  logic mode = 1'b1;
  logic ovr = 1'b0;
  logic lfps = 1'b0;
  logic lp = 1'b0;
  logic [1:0] a_hi = 2'h0;
  logic [1:0] a_lo = 2'h0;
  logic [1:0] gstrap = 2'h2;
  logic [1:0] fsm_req = 2'h0;
  logic [3:0] gain;
  logic lp_exit, det_en, det_stb, c_dfp, c_ufp, c_flag, ok;
  logic [7:0] rd;
  logic [6:0] dev = 7'h12;
  logic [7:0] exp_per [4] = '{8'h28, 8'h3c, 8'h50, 8'h64};
  int miscompares = 0;
  int checks_done = 0;
  int n;

  always #2.5 clk = ~clk;
  // Pull-up unless either side pulls low
  assign sda = ~sda_low & ~(sda_oe & ~sda_out);

  ssl_i2c_host host (.sda(sda), .scl(scl), .sda_low(sda_low));

  ssl_superspeed_regs #(.DEBOUNCE_CYC(20), .DET_P0_CYC(40), .DET_P1_CYC(60), .DET_P2_CYC(80),
    .DET_P3_CYC(100)) uut (
    .clk(clk), .reset_n(reset_n), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .i2c_mode_select(mode), .address_strap_high(a_hi), .address_strap_low(a_lo),
    .upstream_gain_strap_pins(gstrap), .gain_software_override(ovr), .lfps_detect(lfps),
    .low_power_state(lp), .compliance_fsm_req(fsm_req), .upstream_rx_gain_select(gain),
    .low_power_exit(lp_exit), .rx_detect_enable(det_en), .rx_detect_strobe(det_stb),
    .compliance_dfp(c_dfp), .compliance_ufp(c_ufp), .compliance_state_flag(c_flag));

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h0, got}, {7'h0, exp});
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    tick(8);
    reset_n = 1'b1;
    #1000;
    tick(1);
  endtask

  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    host.write_reg(dev, off, d, ok);
    check_bit(ok, 1'b1);
    tick(2);
  endtask

  task automatic rdchk(input logic [7:0] off, input logic [7:0] exp);
    host.read_reg(dev, off, rd, ok);
    check_bit(ok, 1'b1);
    check_byte(rd, exp);
    tick(1);
  endtask

  // Cycles between two strobes, bounded so a dead counter cannot hang
  task automatic period(output int k);
    k = 0;
    while (det_stb !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    tick(1);
    k = 1;
    while (det_stb !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    end_of_test();
  end

  initial begin
    do_reset();
    check_bit(det_en, 1'b1);
    check_byte({4'h0, gain}, 8'h02);
    rdchk(8'h21, 8'h02);
    rdchk(8'h22, 8'h04);
    rdchk(8'h30, 8'h00);
    wr(8'h21, 8'hfb);
    rdchk(8'h21, 8'h02);
    $display("test reset_and_strap done");
    ovr = 1'b1;
    for (int g = 0; g < 16; g++) begin
      wr(8'h21, {4'ha, g[3:0]});
      check_byte({4'h0, gain}, {4'h0, g[3:0]});
    end
    rdchk(8'h21, 8'h0f);
    lfps = 1'b1;
    tick(4);
    check_byte({4'h0, gain}, 8'h00);
    wr(8'h22, 8'h44);
    check_byte({4'h0, gain}, 8'h0f);
    $display("test gain done");
    lp = 1'b1;
    tick(5);
    check_bit(lp_exit, 1'b1);
    check_bit(det_en, 1'b1);
    lp = 1'b0;
    lfps = 1'b0;
    wr(8'h22, 8'h24);
    lp = 1'b1;
    lfps = 1'b1;
    tick(12);
    check_bit(lp_exit, 1'b0);
    tick(16);
    check_bit(lp_exit, 1'b1);
    wr(8'h22, 8'h14);
    check_bit(det_en, 1'b0);
    lp = 1'b0;
    lfps = 1'b0;
    tick(4);
    check_bit(det_en, 1'b1);
    $display("test low_power done");
    for (int p = 0; p < 4; p++) begin
      wr(8'h22, {4'h0, p[1:0], 2'h3});
      period(n);
      check_byte(n[7:0], exp_per[p]);
    end
    $display("test detect_period done");
    fsm_req = 2'h3;
    for (int c = 0; c < 4; c++) begin
      wr(8'h22, {6'h01, c[1:0]});
      check_bit(c_dfp, c < 2);
      check_bit(c_ufp, c == 0 || c == 2);
      check_bit(c_flag, c < 3);
      rdchk(8'h22, {c < 3, 5'h01, c[1:0]});
    end
    $display("test compliance done");
    mode = 1'b0;
    tick(4);
    check_byte({4'h0, gain}, 8'h02);
    host.write_reg(7'h12, 8'h21, 8'h05, ok);
    check_bit(ok, 1'b0);
    tick(1);
    mode = 1'b1;
    host.write_reg(7'h13, 8'h21, 8'h05, ok);
    check_bit(ok, 1'b0);
    tick(1);
    a_hi = 2'h1;
    a_lo = 2'h2;
    // Quiet compliance request so the reset value of 0x22 shows unmasked
    fsm_req = 2'h0;
    do_reset();
    host.write_reg(7'h12, 8'h21, 8'h05, ok);
    check_bit(ok, 1'b0);
    dev = 7'h18;
    rdchk(8'h22, 8'h04);
    wr(8'h21, 8'h05);
    rdchk(8'h21, 8'h05);
    $display("test address done");
    end_of_test();
  end
endmodule
